// [core_map.svh]
// Contract
// RULE_01: the clock is divided by four into four non-overlapping phases per instruction cycle
// RULE_02: the program counter advances once per cycle in phase one, starting the next fetch
// RULE_03: the fetched program word is captured by the end of phase four
// RULE_04: fetch of the next word overlaps execution of the current one
// RULE_05: a counter change flushes the prefetched word, so that instruction takes two cycles
// RULE_06: the fetched word enters the instruction register in phase one, executes in two-four
// RULE_07: the operand read happens in phase two and the destination write in phase four
// RULE_08: the 13-bit program counter spans 8K words of 14 bits, 0000h to 1FFFh
// RULE_09: execution starts at 0000h after reset; an accepted interrupt goes to 0004h
// RULE_10: status bits 6:5 select data bank 0 to 3 for direct accesses
// RULE_11: each bank holds 128 bytes; low offsets are special registers, the rest static RAM
// RULE_12: pointer, status, counter low, latch and interrupt registers appear in all banks; the code has no interrupt register, only the other four
// RULE_13: the register file is reached directly in a bank or through the indirect pointer
// RULE_14: unimplemented locations read as zero and ignore writes
// RULE_15: reserved bank-three locations may hold internal state instead of reading zero
// RULE_16: software on the small package keeps the missing port and direction bits clear
// RULE_17: upper counter bits come from a holding latch on low-byte write or branch
// RULE_18: the indirect location uses the pointer as address and is not a physical register
// RULE_19: offsets 70h-7Fh of every bank reach the same bytes as bank zero
`ifndef CORE_MAP_SVH
`define CORE_MAP_SVH
`define PC_RESET 13'h0000
`define PC_IRQ_VECTOR 13'h0004
`define PC_INC 13'h0001
`define STATUS_RESET 8'h18
`define STATUS_RO_MASK 8'h18
`define FSR_RESET 8'h00
`define PROGRAM_COUNTER_HIGH_LATCH_RESET 5'h00
`define STATUS_IRP_BIT 7
`define STATUS_BANK_HI 6
`define STATUS_BANK_LO 5
`define SFR_INDIRECT 7'h00
`define SFR_PCL 7'h02
`define SFR_STATUS 7'h03
`define SFR_FSR 7'h04
`define SFR_PROGRAM_COUNTER_HIGH_LATCH 7'h0A
`define GPR_FIRST 7'h20
`define GPR_SHARED 7'h70
`define GPR_BANK12_LAST 7'h6F
`define GPR_BANK3_LAST 7'h5F
`define RAM_BASE_B1 9'h060
`define RAM_BASE_B2 9'h0B0
`define RAM_BASE_B3 9'h100
`define REG_CTRL 8'h00
`define REG_STATE 8'h04
`define REG_INSTR 8'h08
`define REG_CORE 8'h0C
`define CTRL_RUN_BIT 0
`define CTRL_IRQ_BIT 1
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// [core_pipeline.sv]
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`include "core_map.svh"
module core_pipeline
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// program memory
	output core_pkg::pc_t prog_addr,
	input wire core_pkg::word_t prog_data,
	// instruction stream
	output core_pkg::instr_s instr,
	input wire core_pkg::exec_req_s exec_req,
	output logic [7:0] exec_rdata,
	// phases
	output logic [3:0] q
);
	import core_pkg::*;
	// ----------------------------------------
	// state
	// ----------------------------------------
	phase_e phase;
	logic run_reg, irq_pend_reg, cyc_active_reg, fetch_valid_reg;
	pc_t pc_reg, prog_addr_reg;
	word_t fetch_word_reg;
	instr_s ir_reg;
	logic [7:0] status_reg, fsr_reg, exec_rdata_reg, ram_rdata;
	logic [4:0] program_counter_high_latch_reg;
	logic [8:0] op_addr_reg;
	gpr_loc_s op_loc_reg;
	phase_gen u_phase
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.phase(phase),
		.q(q)
	);
	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic [8:0] full_addr(input logic [6:0] off, input logic [7:0] st,
		input logic [7:0] ptr);
		if (off == `SFR_INDIRECT)
			full_addr = {st[`STATUS_IRP_BIT], ptr}; // [RULE_13] [RULE_18]
		else
			full_addr = {st[`STATUS_BANK_HI], st[`STATUS_BANK_LO], off}; // [RULE_10]
	endfunction

	// bank-three reserved slots read zero; no internal state is kept there [RULE_15]
	function automatic gpr_loc_s gpr_loc(input logic [8:0] a);
		logic [6:0] off;
		logic [8:0] rel;
		off = a[6:0];
		rel = 9'(off - `GPR_FIRST);
		gpr_loc = '{hit: 1'b0, idx: 9'h000};
		if (off >= `GPR_SHARED)
			gpr_loc = '{hit: 1'b1, idx: rel}; // [RULE_19]
		else if (off >= `GPR_FIRST)
		begin
			case (a[8:7]) // [RULE_11]
				2'b00: gpr_loc = '{hit: 1'b1, idx: rel};
				2'b01: gpr_loc = '{hit: off <= `GPR_BANK12_LAST, idx: 9'(`RAM_BASE_B1 + rel)};
				2'b10: gpr_loc = '{hit: off <= `GPR_BANK12_LAST, idx: 9'(`RAM_BASE_B2 + rel)};
				2'b11: gpr_loc = '{hit: off <= `GPR_BANK3_LAST, idx: 9'(`RAM_BASE_B3 + rel)};
				default: gpr_loc = '{hit: 1'b0, idx: 9'h000};
			endcase
		end
	endfunction

	logic [8:0] cur_addr;
	gpr_loc_s cur_loc;
	logic ex_act, q4_act, wr_act, pcl_wr, redirect, ram_we;
	assign cur_addr = full_addr(exec_req.file_addr, status_reg, fsr_reg);
	assign cur_loc = gpr_loc(cur_addr);
	assign q4_act = (phase == PH_Q4) && cyc_active_reg;
	assign ex_act = cyc_active_reg && ir_reg.valid;
	assign wr_act = (phase == PH_Q4) && ex_act && exec_req.wr_en; // [RULE_07]
	assign pcl_wr = wr_act && (op_addr_reg[6:0] == `SFR_PCL);
	assign redirect = q4_act && ((ex_act && exec_req.branch) || pcl_wr || irq_pend_reg);
	assign ram_we = wr_act && op_loc_reg.hit; // [RULE_14]
	data_ram u_ram
	(
		.aclk(aclk),
		.we(ram_we),
		.waddr(op_loc_reg.idx),
		.wdata(exec_req.wdata),
		.re((phase == PH_Q2) && ex_act),
		.raddr(cur_loc.idx),
		.rdata(ram_rdata)
	);
	// ----------------------------------------
	// program counter and fetch
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pc_reg <= `PC_RESET; // [RULE_09]
		else if ((phase == PH_Q1) && run_reg)
			pc_reg <= pc_reg + `PC_INC; // [RULE_02] [RULE_08]
		else if (q4_act && ex_act && exec_req.branch)
			pc_reg <= {program_counter_high_latch_reg[4:3], exec_req.target}; // [RULE_17]
		else if (pcl_wr)
			pc_reg <= {program_counter_high_latch_reg, exec_req.wdata}; // [RULE_17]
		else if (q4_act && irq_pend_reg)
			pc_reg <= `PC_IRQ_VECTOR; // [RULE_09]
	end
	// fetch of the next word runs while the held word executes [RULE_04]
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prog_addr_reg <= `PC_RESET;
			cyc_active_reg <= 1'b0;
			fetch_word_reg <= 14'h0000;
			fetch_valid_reg <= 1'b0;
			ir_reg <= '{valid: 1'b0, word: 14'h0000};
		end
		else if (phase == PH_Q1)
		begin
			prog_addr_reg <= pc_reg; // [RULE_02]
			cyc_active_reg <= run_reg;
			ir_reg <= '{valid: run_reg && fetch_valid_reg, word: fetch_word_reg}; // [RULE_06]
		end
		else if (q4_act)
		begin
			fetch_word_reg <= prog_data; // [RULE_03]
			fetch_valid_reg <= !redirect; // [RULE_05]
		end
	end
	// ----------------------------------------
	// data memory access
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			op_addr_reg <= 9'h000;
			op_loc_reg <= '{hit: 1'b0, idx: 9'h000};
		end
		else if ((phase == PH_Q2) && ex_act)
		begin
			op_addr_reg <= cur_addr; // [RULE_07]
			op_loc_reg <= cur_loc;
		end
	end
	// core registers decode on offset alone, so they show in every bank
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			exec_rdata_reg <= 8'h00;
		else if ((phase == PH_Q3) && ex_act)
		begin
			case (op_addr_reg[6:0]) // [RULE_12]
				`SFR_PCL: exec_rdata_reg <= pc_reg[7:0];
				`SFR_STATUS: exec_rdata_reg <= status_reg;
				`SFR_FSR: exec_rdata_reg <= fsr_reg;
				`SFR_PROGRAM_COUNTER_HIGH_LATCH: exec_rdata_reg <= {3'h0, program_counter_high_latch_reg};
				default: exec_rdata_reg <= op_loc_reg.hit ? ram_rdata : 8'h00; // [RULE_14] [RULE_18]
			endcase
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			status_reg <= `STATUS_RESET;
			fsr_reg <= `FSR_RESET;
			program_counter_high_latch_reg <= `PROGRAM_COUNTER_HIGH_LATCH_RESET;
		end
		else if (wr_act)
		begin
			case (op_addr_reg[6:0]) // [RULE_12]
				`SFR_STATUS: status_reg <= (exec_req.wdata & ~`STATUS_RO_MASK)
					| (status_reg & `STATUS_RO_MASK);
				`SFR_FSR: fsr_reg <= exec_req.wdata;
				`SFR_PROGRAM_COUNTER_HIGH_LATCH: program_counter_high_latch_reg <= exec_req.wdata[4:0];
				default: ;
			endcase
		end
	end
	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	logic aw_held, w_held, do_write;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = a inside {`REG_CTRL, `REG_STATE, `REG_INSTR, `REG_CORE};
	endfunction

	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign arready = !rvalid;
	assign do_write = aw_held && w_held;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `AXI_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held <= 1'b1;
				aw_addr_reg <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held <= 1'b1;
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= known_addr(aw_addr_reg) ? `AXI_OKAY : `AXI_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end
	// the request is set even if it lands on the edge that takes it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			run_reg <= 1'b0;
			irq_pend_reg <= 1'b0;
		end
		else
		begin
			if (q4_act && irq_pend_reg && !(ex_act && exec_req.branch) && !pcl_wr)
				irq_pend_reg <= 1'b0;
			if (do_write && (aw_addr_reg == `REG_CTRL) && w_strb_reg[0])
			begin
				run_reg <= w_data_reg[`CTRL_RUN_BIT];
				if (w_data_reg[`CTRL_IRQ_BIT])
					irq_pend_reg <= 1'b1;
			end
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `AXI_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rresp <= known_addr(araddr) ? `AXI_OKAY : `AXI_SLVERR;
			case (araddr)
				`REG_CTRL: rdata <= {30'h00000000, irq_pend_reg, run_reg};
				`REG_STATE: rdata <= 32'({fetch_valid_reg, cyc_active_reg, phase, pc_reg});
				`REG_INSTR: rdata <= 32'(ir_reg);
				`REG_CORE: rdata <= 32'({program_counter_high_latch_reg, fsr_reg, status_reg});
				default: rdata <= 32'h00000000;
			endcase
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end
	assign prog_addr = prog_addr_reg;
	assign instr = ir_reg;
	assign exec_rdata = exec_rdata_reg;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_pc_advance: assert property ((phase == PH_Q1) && run_reg |=> // [RULE_02]
		pc_reg == 13'($past(pc_reg) + `PC_INC))
		else $error("counter did not advance in phase one");
	a_fetch_capture: assert property (q4_act |=> fetch_word_reg == $past(prog_data)) // [RULE_03]
		else $error("program word not captured in phase four");
	a_ir_load: assert property ((phase == PH_Q1) && run_reg && fetch_valid_reg |=> // [RULE_06]
		ir_reg.valid && (ir_reg.word == $past(fetch_word_reg)))
		else $error("instruction register not loaded in phase one");
	a_flush_bubble: assert property (redirect |=> !fetch_valid_reg ##1 (!ir_reg.valid)[*4]) // [RULE_05]
		else $error("prefetched word not flushed");
	a_reset_vector: assert property ($rose(aresetn) |-> pc_reg == `PC_RESET) // [RULE_09]
		else $error("reset vector wrong");
	a_irq_vector: assert property (q4_act && irq_pend_reg && !(ex_act && exec_req.branch) // [RULE_09]
		&& !pcl_wr |=> pc_reg == `PC_IRQ_VECTOR)
		else $error("interrupt vector wrong");
	a_write_phase: assert property (ram_we |-> (phase == PH_Q4) && !$stable(q)) // [RULE_07]
		else $error("data write outside phase four");
	a_unimp_zero: assert property ((phase == PH_Q3) && ex_act && !op_loc_reg.hit // [RULE_14]
		&& !(op_addr_reg[6:0] inside {`SFR_PCL, `SFR_STATUS, `SFR_FSR, `SFR_PROGRAM_COUNTER_HIGH_LATCH})
		|=> exec_rdata_reg == 8'h00)
		else $error("unimplemented location read nonzero");
	a_pcl_latch: assert property (pcl_wr && !(ex_act && exec_req.branch) |=> // [RULE_17]
		pc_reg[12:8] == $past(program_counter_high_latch_reg))
		else $error("upper counter not taken from latch");
	a_bank_select: assert property ((phase == PH_Q2) && ex_act // [RULE_10]
		&& (exec_req.file_addr != `SFR_INDIRECT) |=> op_addr_reg[8:7] == $past(status_reg[6:5]))
		else $error("bank select not applied");
endmodule // core_pipeline

// [core_pipeline_and_memory_banking_tb.sv]
`timescale 1ns/10ps
`include "core_map.svh"
module core_pipeline_and_memory_banking_tb;
	import core_pkg::*;
	localparam word_t FILL = 14'h1555;
	localparam exec_req_s IDLE = '0;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, found;
	logic [7:0] awaddr, araddr, exec_rdata, rd;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb, q;
	logic [1:0] bresp, rresp, resp;
	pc_t prog_addr;
	word_t prog_data;
	instr_s instr, seen;
	exec_req_s exec_req;
	int n_fail, tests_run;
	core_pipeline dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.prog_addr(prog_addr), .prog_data(prog_data), .instr(instr), .exec_req(exec_req),
		.exec_rdata(exec_rdata), .q(q));
	prog_mem_model #(.FILL(FILL)) mem (.prog_addr(prog_addr), .prog_data(prog_data));
	initial aclk = 1'b0;
	always #50 aclk = ~aclk;
	// ---------------------------------------------------
	// shared tasks
	// ---------------------------------------------------
	function automatic word_t pw(pc_t a);
		pw = {1'b0, a} ^ FILL;
	endfunction
	function automatic exec_req_s mk(logic br, logic [10:0] t, logic we, logic [6:0] fa,
		logic [7:0] wd);
		mk = '{branch: br, target: t, wr_en: we, file_addr: fa, wdata: wd};
	endfunction
	task automatic check(input string name, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, e, s);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ready is sampled at the falling edge; nothing moves between it and the rising edge
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		logic pa = 1'b1;
		logic pd = 1'b1;
		logic tb = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pd)
		begin
			@(negedge aclk);
			pa = pa && !awready;
			pd = pd && !wready;
			@(posedge aclk);
			awvalid <= pa;
			wvalid <= pd;
		end
		while (!tb)
		begin
			@(negedge aclk);
			tb = bvalid;
			resp = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [7:0] a);
		logic pa = 1'b1;
		logic tr = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (pa)
		begin
			@(negedge aclk);
			pa = !arready;
			@(posedge aclk);
			arvalid <= pa;
		end
		while (!tr)
		begin
			@(negedge aclk);
			tr = rvalid;
			resp = rresp;
			rv = rdata;
			@(posedge aclk);
		end
		rready <= 1'b0;
	endtask
	// one instruction cycle: request held from the end of Q1 to the next end of Q1
	task automatic op(input exec_req_s r);
		@(negedge aclk);
		while (q !== 4'b0001)
			@(negedge aclk);
		@(posedge aclk);
		exec_req <= r;
		#1 seen = instr;
		repeat (2) @(posedge aclk);
		#1 rd = exec_rdata;
	endtask
	task automatic ichk(input string name, input pc_t a);
		check(name, 32'(seen), 32'({1'b1, pw(a)}));
	endtask
	task automatic wr(input logic [6:0] fa, input logic [7:0] wd);
		op(mk(1'b0, 11'h000, 1'b1, fa, wd));
		check("write valid", 32'(seen.valid), 32'h1);
	endtask
	task automatic rdchk(input string name, input logic [6:0] fa, input logic [7:0] e);
		op(mk(1'b0, 11'h000, 1'b0, fa, 8'h00));
		check(name, 32'(rd), 32'(e));
	endtask
	// ---------------------------------------------------
	// scenarios
	// ---------------------------------------------------
	task t_reset;
		axi_read(`REG_CORE);
		check("core reset", rv, 32'h0000_0018);
		axi_read(`REG_STATE);
		check("pc reset", 32'(rv[12:0]), 32'h0);
		axi_read(8'h10);
		check("rresp", 32'(resp), 32'(`AXI_SLVERR));
		axi_write(8'h10, 32'h0000_00FF);
		check("bresp", 32'(resp), 32'(`AXI_SLVERR));
		@(negedge aclk);
		while (q !== 4'b0001)
			@(negedge aclk);
		for (int i = 0; i < 8; i++)
		begin
			check("phase", 32'(q), 32'(4'b0001 << (i % 4)));
			check("idle addr", 32'(prog_addr), 32'h0);
			@(negedge aclk);
		end
	endtask
	task t_stream;
		axi_write(`REG_CTRL, 32'h0000_0001);
		check("run bresp", 32'(resp), 32'(`AXI_OKAY));
		seen = '0;
		for (int i = 0; i < 4 && seen.valid !== 1'b1; i++)
			op(IDLE);
		ichk("first word", 13'h0000);
		op(IDLE);
		ichk("second word", 13'h0001);
	endtask
	task t_branch;
		op(mk(1'b1, 11'h123, 1'b0, 7'h00, 8'h00));
		op(IDLE);
		check("flush", 32'(seen.valid), 32'h0);
		op(IDLE);
		ichk("target", 13'h0123);
		op(IDLE);
		ichk("after target", 13'h0124);
	endtask
	task t_data;
		wr(7'h04, 8'h20);
		wr(7'h20, 8'h5A);
		wr(7'h75, 8'h3C);
		wr(7'h05, 8'hFF);
		rdchk("ram", 7'h20, 8'h5A);
		rdchk("indirect", 7'h00, 8'h5A);
		rdchk("unimplemented", 7'h05, 8'h00);
		wr(7'h03, 8'h20);
		axi_read(`REG_CORE);
		check("bank one", rv, 32'h0000_2038);
		rdchk("shared ram", 7'h75, 8'h3C);
		rdchk("status mirror", 7'h03, 8'h38);
		rdchk("pointer mirror", 7'h04, 8'h20);
		wr(7'h08, 8'h00);
		rdchk("direction d", 7'h08, 8'h00);
		wr(7'h03, 8'h60);
		wr(7'h65, 8'hAA);
		rdchk("reserved", 7'h65, 8'h00);
		rdchk("bank three shared", 7'h75, 8'h3C);
		wr(7'h03, 8'h00);
	endtask
	task t_pcl;
		wr(7'h0A, 8'h01);
		wr(7'h02, 8'h40);
		op(IDLE);
		check("pcl flush", 32'(seen.valid), 32'h0);
		op(IDLE);
		ichk("latch jump", 13'h0140);
	endtask
	task t_irq;
		axi_write(`REG_CTRL, 32'h0000_0003);
		found = 1'b0;
		for (int i = 0; i < 6 && !found; i++)
		begin
			op(IDLE);
			found = (seen === {1'b1, pw(13'h0004)});
		end
		check("vector", 32'(found), 32'h1);
		op(IDLE);
		ichk("after vector", 13'h0005);
		axi_read(`REG_CTRL);
		check("ctrl", rv, 32'h0000_0001);
	endtask
	// ---------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------
	initial
	begin
		n_fail = 0;
		tests_run = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		exec_req = IDLE;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_stream;
		t_branch;
		t_data;
		t_pcl;
		t_irq;
		stop_test;
	end
	// the whole sequence needs well under a thousand clocks
	initial
	begin
		#2_000_000;
		n_fail++;
		stop_test;
	end
endmodule // core_pipeline_and_memory_banking_tb

// [core_pkg.sv]
package core_pkg;
	typedef enum logic [1:0]
	{
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} phase_e;
	typedef logic [12:0] pc_t;
	typedef logic [13:0] word_t;
	typedef struct packed {
		logic valid;
		word_t word;
	} instr_s;
	typedef struct packed {
		logic branch;
		logic [10:0] target;
		logic wr_en;
		logic [6:0] file_addr;
		logic [7:0] wdata;
	} exec_req_s;
	typedef struct packed {
		logic hit;
		logic [8:0] idx;
	} gpr_loc_s;
endpackage

// [data_ram.sv]
`timescale 1ns/10ps
module data_ram
(
	// clock
	input wire logic aclk,
	// write port
	input wire logic we,
	input wire logic [8:0] waddr,
	input wire logic [7:0] wdata,
	// read port
	input wire logic re,
	input wire logic [8:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:511];

	always_ff @(posedge aclk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge aclk)
	begin
		if (re)
			rdata <= mem[raddr];
	end
endmodule // data_ram

// [phase_gen.sv]
`timescale 1ns/10ps
`include "core_map.svh"
module phase_gen
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// quadrature phases
	output core_pkg::phase_e phase,
	output logic [3:0] q
);
	import core_pkg::*;
	phase_e phase_reg;
	phase_e phase_next;
	logic [3:0] q_reg;

	always_comb
	begin
		case (phase_reg)
			PH_Q1: phase_next = PH_Q2;
			PH_Q2: phase_next = PH_Q3;
			PH_Q3: phase_next = PH_Q4;
			PH_Q4: phase_next = PH_Q1;
			default: phase_next = PH_Q1;
		endcase
	end

	// divide by four into one-hot phases [RULE_01]
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			phase_reg <= PH_Q1;
			q_reg <= 4'h1;
		end
		else
		begin
			phase_reg <= phase_next;
			q_reg <= 4'(4'h1 << phase_next);
		end
	end

	assign phase = phase_reg;
	assign q = q_reg;

	a_phase_onehot: assert property (@(posedge aclk) disable iff (!aresetn) $onehot(q_reg)) // [RULE_01]
		else $error("phase outputs not one-hot");
	a_phase_order: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_01]
		q_reg[0] |=> q_reg[1] ##1 q_reg[2] ##1 q_reg[3] ##1 q_reg[0])
		else $error("phase sequence broken");
endmodule // phase_gen

// [prog_mem_model.sv]
`timescale 1ns/10ps
module prog_mem_model
import core_pkg::*;
#(parameter word_t FILL = 14'h1555)
(
	// program memory port
	input wire core_pkg::pc_t prog_addr,
	output core_pkg::word_t prog_data
);
	// ---------------------------------------------------
	// program store
	// ---------------------------------------------------
	// every word differs from its neighbours, so a fetch from a wrong address shows at once
	assign prog_data = {1'b0, prog_addr} ^ FILL;
endmodule // prog_mem_model
